// File: dv/vc0_resource_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vc0_resource_regs_tb;
    import vcr_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, upstream_port = 1'b1;
    logic override_valid = 1'b0, table_entry_written = 1'b0, negotiation_pending = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rd, hrdata;
    logic [6:0] override_max_slots = 7'h00;
    logic [7:0] override_class_map = 8'h00, class_to_channel_map;
    logic hreadyout, hresp, virtual_channel_enable, table_load_pulse, table_loading;
    logic [2:0] arb_select;
    int error_cnt = 0, n_checks = 0, s;
    // bus clock
    always #20 hclk = ~hclk;
    vcr_regs #(.TABLE_ENTRIES(4)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .upstream_port, .override_valid, .override_max_slots,
        .override_class_map, .table_entry_written, .negotiation_pending, .class_to_channel_map, .arb_select,
        .virtual_channel_enable, .table_load_pulse, .table_loading);
    task wrap_up;
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // bounded waits; a ready hang ends the run, a load hang only fails a check
    task wait_rdy;
        int i;
        i = 0;
        do
        begin
            @(posedge hclk);
            i++;
        end
        while (hreadyout !== 1'b1 && i < 50);
        if (i >= 50)
        begin
            chk({31'h0, hreadyout}, 32'h1);
            wrap_up();
        end
    endtask : wait_rdy
    task wait_load;
        @(posedge hclk);
        for (s = 0; table_loading === 1'b1 && s < 50; s++)
            @(posedge hclk);
        chk({31'h0, table_loading}, 32'h0);
    endtask : wait_load
    // one single-word transfer, address phase then data phase
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= VCR_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : xfer
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    // main sequence
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(VCR_CAP_OFFSET, 32'h047F0009);
        rdchk(VCR_CTL_OFFSET, 32'h800000FF);
        rdchk(VCR_STS_OFFSET, 32'h0);
        rdchk(12'h15C, 32'h0);
        xfer(1'b1, VCR_CTL_OFFSET, 32'hFFFFFF5A);
        wait_load();
        rdchk(VCR_CTL_OFFSET, 32'h8000005A);
        chk({24'h0, class_to_channel_map}, 32'h5A);
        for (int k = 0; k < 8; k++)
        begin
            xfer(1'b1, VCR_CTL_OFFSET, 32'h80000000 | (32'(k) << 17) | 32'(k));
            rdchk(VCR_CTL_OFFSET, 32'h80000000 | (k == 3 ? 32'h60000 : 32'h0) | 32'(k));
            chk({29'h0, arb_select}, k == 3 ? 32'h3 : 32'h0);
        end
        xfer(1'b1, VCR_CTL_OFFSET, 32'h000600C3);
        rdchk(VCR_CTL_OFFSET, 32'h000600C3);
        chk({31'h0, virtual_channel_enable}, 32'h0);
        @(posedge hclk) table_entry_written <= 1'b1;
        negotiation_pending <= 1'b1;
        @(posedge hclk) table_entry_written <= 1'b0;
        rdchk(VCR_STS_OFFSET, 32'h00030000);
        xfer(1'b1, VCR_CTL_OFFSET, 32'h00010000);
        rdchk(VCR_STS_OFFSET, 32'h00030000);
        wait_load();
        negotiation_pending <= 1'b0;
        @(posedge hclk);
        rdchk(VCR_STS_OFFSET, 32'h0);
        @(posedge hclk) override_valid <= 1'b1;
        override_max_slots <= 7'h12;
        override_class_map <= 8'h3C;
        @(posedge hclk) override_valid <= 1'b0;
        rdchk(VCR_CAP_OFFSET, 32'h04120009);
        rdchk(VCR_CTL_OFFSET, 32'h0000003C);
        upstream_port <= 1'b0;
        rdchk(VCR_CAP_OFFSET, 32'h0);
        xfer(1'b1, VCR_CTL_OFFSET, 32'h800000FF);
        upstream_port <= 1'b1;
        rdchk(VCR_CTL_OFFSET, 32'h0000003C);
        wrap_up();
    end
endmodule : vc0_resource_regs_tb
`default_nettype wire

// File: dv/vcr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module vcr_regs_monitor
    import vcr_pkg::*;
#(
    parameter int TABLE_ENTRIES = VCR_TABLE_ENTRIES
)
(
    input wire logic hclk, // clock
    input wire logic hresetn, // reset
    input wire logic hreadyout, // ready
    input wire logic hresp, // response
    input wire logic override_valid, // override strobe
    input wire logic [7:0] override_class_map, // override map
    input wire logic [7:0] class_to_channel_map, // map out
    input wire logic [2:0] arb_select, // scheme
    input wire logic table_load_pulse, // load pulse
    input wire logic table_loading // load busy
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    int run_cnt;
    // counts cycles of one table load
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            run_cnt <= 0;
        else
            run_cnt <= table_loading ? run_cnt + 1 : 0;
    // bus answer, load sequencing, scheme and override
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not ready okay");
    property p_pulse; table_load_pulse |=> !table_load_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("load pulse too long");
    property p_start; table_load_pulse |-> table_loading; endproperty
    a_start: assert property (p_start) else $error("load did not start");
    property p_len; $fell(table_loading) |-> run_cnt == TABLE_ENTRIES; endproperty
    a_len: assert property (p_len) else $error("load length wrong");
    property p_rise; $rose(table_loading) |-> table_load_pulse; endproperty
    a_rise: assert property (p_rise) else $error("load without request");
    property p_busy; table_loading && $past(table_loading) |-> !table_load_pulse; endproperty
    a_busy: assert property (p_busy) else $error("load request while loading");
    property p_sel; arb_select == VCR_SEL_DEFAULT || arb_select == VCR_SEL_TIMED; endproperty
    a_sel: assert property (p_sel) else $error("illegal scheme");
    property p_ovr; override_valid |=> class_to_channel_map == $past(override_class_map); endproperty
    a_ovr: assert property (p_ovr) else $error("override not taken");
endmodule : vcr_regs_monitor
bind vcr_regs vcr_regs_monitor #(.TABLE_ENTRIES(TABLE_ENTRIES)) u_mon (.hclk, .hresetn, .hreadyout, .hresp,
    .override_valid, .override_class_map, .class_to_channel_map, .arb_select, .table_load_pulse, .table_loading);
`default_nettype wire

// File: verilog/vcr_pkg.sv
`default_nettype none
package vcr_pkg;
    // byte addresses of the three registers
    localparam logic [11:0] VCR_CAP_OFFSET = 12'h150;
    localparam logic [11:0] VCR_CTL_OFFSET = 12'h154;
    localparam logic [11:0] VCR_STS_OFFSET = 12'h158;
    // capability fields
    localparam logic [7:0] VCR_ARB_CAP = 8'h09;
    localparam logic [6:0] VCR_MAX_SLOTS_RESET = 7'h7F;
    localparam logic [7:0] VCR_TABLE_OFFSET = 8'h04;
    localparam int VCR_SLOTS_LSB = 16;
    localparam int VCR_TABLE_OFF_LSB = 24;
    localparam int VCR_ADV_SWITCH_BIT = 14;
    localparam int VCR_REJECT_SNOOP_BIT = 15;
    // control fields
    localparam logic [7:0] VCR_CLASS_MAP_RESET = 8'hFF;
    localparam int VCR_LOAD_BIT = 16;
    localparam int VCR_SEL_LSB = 17;
    localparam int VCR_ID_LSB = 24;
    localparam int VCR_ENABLE_BIT = 31;
    localparam logic [2:0] VCR_SEL_DEFAULT = 3'h0;
    localparam logic [2:0] VCR_SEL_TIMED = 3'h3;
    localparam logic [2:0] VCR_CHANNEL_ID = 3'h0;
    localparam logic VCR_ENABLE_RESET = 1'b1;
    // status fields
    localparam int VCR_TBL_DIRTY_BIT = 16;
    localparam int VCR_NEG_PEND_BIT = 17;
    // arbitration table size and load time
    localparam int VCR_TABLE_ENTRIES = 128;
    localparam logic [7:0] VCR_LOAD_CYCLES = 8'h80;
    // htrans encodings
    localparam logic [1:0] VCR_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] VCR_HTRANS_SEQ = 2'h3;
endpackage : vcr_pkg
`default_nettype wire

// File: verilog/vcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE1] capability arbitration field reads fixed 00001001b: round robin and one 128-phase scheme
// [RULE2] capability bit 14, packet-switching-only, reads zero
// [RULE3] capability bit 15, reject snoop, reads zero
// [RULE4] capability bits 22:16 give time slots minus one, 7Fh after reset
// [RULE5] time slot default can be overridden by side-band bus or serial memory
// [RULE6] capability bits 31:24 give table offset in 16-byte units, 04h
// [RULE7] control bits 7:0 map each traffic class to the channel, FFh after reset
// [RULE8] class map default can be overridden by side-band bus or serial memory
// [RULE9] writing one to control bit 16 applies the table; reads zero
// [RULE10] scheme select 19:17 accepts 000b or 011b; others become default
// [RULE11] control bits 26:24 channel identifier read 000b
// [RULE12] control bit 31 enables the channel, one after reset
// [RULE13] status bit 16 sets on any software table entry write
// [RULE14] status bit 16 clears only when the table load finishes
// [RULE15] status bit 17 is one while negotiation is pending
// [RULE16] registers sit at 150h, 154h, 158h on the upstream port only
// [RULE17] the loaded arbitration table holds 128 entries
// [RULE18] reserved bits read zero, ignore writes; load request is a one-cycle pulse
module vcr_regs
    import vcr_pkg::*;
#(
    parameter int TABLE_ENTRIES = VCR_TABLE_ENTRIES
)
(
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [11:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic upstream_port, // high when this port is upstream
    input wire logic override_valid, // side-band or serial-memory override strobe
    input wire logic [6:0] override_max_slots, // override time slots value
    input wire logic [7:0] override_class_map, // override class map value
    input wire logic table_entry_written, // software wrote an arbitration table entry
    input wire logic negotiation_pending, // channel negotiation still running
    output logic [7:0] class_to_channel_map, // traffic class map
    output logic [2:0] arb_select, // effective arbitration scheme
    output logic virtual_channel_enable, // channel enable
    output logic table_load_pulse, // one-cycle table apply request
    output logic table_loading // table load in progress
);

    typedef struct packed {
        logic wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        logic [6:0] max_slots;
        logic [7:0] class_map;
        logic [2:0] sel;
        logic enable;
        logic load_pulse;
        logic loading;
        logic [7:0] load_cnt;
        logic tbl_dirty;
        logic neg_pend;
    } vcr_state_t;

    vcr_state_t st_reg;
    vcr_state_t st_next;

    // registers exist only on the upstream port
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off, input logic up);
        hit = up && (a[11:2] == off[11:2]); // RULE16
    endfunction : hit

    // read value of a register at a byte address
    function automatic logic [31:0] read_word(input logic [11:0] a, input vcr_state_t s, input logic up);
        read_word = 32'h0000_0000; // RULE18
        if (hit(a, VCR_CAP_OFFSET, up))
        begin
            read_word[7:0] = VCR_ARB_CAP; // RULE1
            read_word[VCR_ADV_SWITCH_BIT] = 1'b0; // RULE2
            read_word[VCR_REJECT_SNOOP_BIT] = 1'b0; // RULE3
            read_word[VCR_SLOTS_LSB +: 7] = s.max_slots; // RULE4
            read_word[VCR_TABLE_OFF_LSB +: 8] = VCR_TABLE_OFFSET; // RULE6
        end
        else if (hit(a, VCR_CTL_OFFSET, up))
        begin
            read_word[7:0] = s.class_map; // RULE7
            read_word[VCR_LOAD_BIT] = 1'b0; // RULE9
            read_word[VCR_SEL_LSB +: 3] = s.sel;
            read_word[VCR_ID_LSB +: 3] = VCR_CHANNEL_ID; // RULE11
            read_word[VCR_ENABLE_BIT] = s.enable; // RULE12
        end
        else if (hit(a, VCR_STS_OFFSET, up))
        begin
            read_word[VCR_TBL_DIRTY_BIT] = s.tbl_dirty;
            read_word[VCR_NEG_PEND_BIT] = s.neg_pend; // RULE15
        end
    endfunction : read_word

    logic addr_ok;
    assign addr_ok = hsel && hready && (htrans == VCR_HTRANS_NONSEQ || htrans == VCR_HTRANS_SEQ);

    // next-state logic: bus slave, control fields, table load sequencing
    always_comb
    begin
        st_next = st_reg;
        st_next.load_pulse = 1'b0; // RULE18
        st_next.neg_pend = negotiation_pending; // RULE15
        st_next.wr_pend = addr_ok && hwrite;
        if (addr_ok)
        begin
            st_next.wr_addr = haddr;
            if (!hwrite)
            begin
                st_next.rdata = read_word(haddr, st_reg, upstream_port);
            end
        end
        // side-band or serial-memory default override
        if (override_valid)
        begin
            st_next.max_slots = override_max_slots; // RULE5
            st_next.class_map = override_class_map; // RULE8
        end
        // data phase of a write
        if (st_reg.wr_pend && hit(st_reg.wr_addr, VCR_CTL_OFFSET, upstream_port))
        begin
            st_next.class_map = hwdata[7:0]; // RULE7
            if (hwdata[VCR_SEL_LSB +: 3] == VCR_SEL_TIMED)
            begin
                st_next.sel = VCR_SEL_TIMED; // RULE10
            end
            else
            begin
                st_next.sel = VCR_SEL_DEFAULT; // RULE10
            end
            st_next.enable = hwdata[VCR_ENABLE_BIT]; // RULE12
            if (hwdata[VCR_LOAD_BIT] && !st_reg.loading)
            begin
                st_next.load_pulse = 1'b1; // RULE9
                st_next.loading = 1'b1;
                st_next.load_cnt = 8'(TABLE_ENTRIES - 1); // RULE17
            end
        end
        // walk the table entries one per cycle while loading
        if (st_reg.loading)
        begin
            if (st_reg.load_cnt == 8'h00)
            begin
                st_next.loading = 1'b0;
            end
            else
            begin
                st_next.load_cnt = st_reg.load_cnt - 8'h01;
            end
        end
        // dirty flag: a write in the finishing cycle keeps it set
        if (st_reg.loading && st_reg.load_cnt == 8'h00)
        begin
            st_next.tbl_dirty = 1'b0; // RULE14
        end
        if (table_entry_written)
        begin
            st_next.tbl_dirty = 1'b1; // RULE13
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_reg <= '0;
            st_reg.max_slots <= VCR_MAX_SLOTS_RESET;
            st_reg.class_map <= VCR_CLASS_MAP_RESET;
            st_reg.sel <= VCR_SEL_DEFAULT;
            st_reg.enable <= VCR_ENABLE_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops, except constant hreadyout and hresp
    assign hrdata = st_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign class_to_channel_map = st_reg.class_map;
    assign arb_select = st_reg.sel;
    assign virtual_channel_enable = st_reg.enable;
    assign table_load_pulse = st_reg.load_pulse;
    assign table_loading = st_reg.loading;

endmodule : vcr_regs
`default_nettype wire
